// ==== hdl/dscd_pkg.sv ====
/*
  constants, enumerations and carrier structs for the debug serial command
  decoder. assumes one 200 MHz clock and a 17-bit serial frame on the link.
*/
`default_nettype none
package dscd_pkg;
    // -------------------------------------------------
    // opcodes
    // -------------------------------------------------
    localparam logic [11:0] OP_RREG = 12'h218;
    localparam logic [11:0] OP_WREG = 12'h208;
    localparam logic [7:0] OP_RMEM = 8'h19;
    localparam logic [7:0] OP_WMEM = 8'h18;
    localparam logic [7:0] OP_DUMP = 8'h1d;
    localparam logic [7:0] OP_FILL = 8'h1c;
    localparam logic [15:0] OP_GO = 16'h0c00;
    localparam logic [15:0] OP_NOP = 16'h0000;
    localparam logic [15:0] OP_SYNC = 16'h0001;
    localparam logic [15:0] OP_RCTL = 16'h2980;
    localparam logic [15:0] OP_WCTL = 16'h2880;
    localparam logic [7:0] OP_RDBG = 8'h2d;
    localparam logic [7:0] OP_WDBG = 8'h2c;
    localparam logic [2:0] OP_DBG_MID = 3'h4;
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    localparam logic [1:0] SZ_RSVD = 2'h3;
    // -------------------------------------------------
    // responses {status, data} and link framing
    // -------------------------------------------------
    localparam logic [16:0] RESP_DONE = 17'h0ffff;
    localparam logic [16:0] RESP_NRDY = 17'h10000;
    localparam logic [16:0] RESP_BERR = 17'h10001;
    localparam logic [16:0] RESP_ILL = 17'h1ffff;
    localparam logic [4:0] FRAME_LAST = 5'h10;
    localparam logic [3:0] TRACE_PC_CODE = 4'h5;
    localparam logic [16:0] TX_RST = RESP_NRDY;
    // -------------------------------------------------
    // types
    // -------------------------------------------------
    typedef enum logic [3:0] {
        ST_CMD = 4'b0001,
        ST_EXT = 4'b0010,
        ST_EXEC = 4'b0100,
        ST_RES = 4'b1000
    } dscd_state_e;
    typedef enum logic [3:0] {
        K_NOP, K_RREG, K_WREG, K_RMEM, K_WMEM, K_DUMP, K_FILL,
        K_GO, K_SYNC, K_RCTL, K_WCTL, K_RDBG, K_WDBG, K_ILL
    } dscd_kind_e;
    typedef enum logic [1:0] {
        SP_GPR = 2'h0,
        SP_CTL = 2'h1,
        SP_DBG = 2'h2
    } dscd_space_e;
    typedef struct packed {
        logic req;
        logic wr;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } dscd_mem_s;
    typedef struct packed {
        logic req;
        logic wr;
        dscd_space_e space;
        logic [11:0] idx;
        logic [31:0] wdata;
    } dscd_reg_s;
endpackage
`default_nettype wire

// ==== hdl/dscd_sync.sv ====
/*
  two-flop synchroniser for a group of levels from outside the clock domain.
  assumes each input changes slowly against clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
module dscd_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import dscd_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } dscd_sync_s;

    dscd_sync_s r_q;
    dscd_sync_s r_d;

    // first stage feeds only the second
    always_comb begin
        r_d.s1 = async_in;
        r_d.s2 = r_q.s1;
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign sync_out = r_q.s2;
endmodule
`default_nettype wire

// ==== hdl/dscd_shift.sv ====
/*
  17-bit serial frame shifter. input bits are taken on link clock rise,
  output bits advance on link clock fall. assumes synchronised inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module dscd_shift (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic link_clk_s_in,
    input wire logic link_data_s_in,
    input wire logic [16:0] tx_word_in,
    output logic [16:0] rx_word_out,
    output logic frame_done_out,
    output logic link_data_out
);
    import dscd_pkg::*;

    typedef struct packed {
        logic prev;
        logic [4:0] cnt;
        logic [16:0] rx;
        logic [16:0] tx;
        logic done;
    } dscd_shift_s;

    dscd_shift_s r_q;
    dscd_shift_s r_d;
    logic rise;
    logic fall;

    // edge finding, bit counting and both shift registers
    always_comb begin
        r_d = r_q;
        rise = link_clk_s_in & ~r_q.prev;
        fall = ~link_clk_s_in & r_q.prev;
        r_d.prev = link_clk_s_in;
        r_d.done = 1'b0;
        if (rise) begin
            r_d.rx = {r_q.rx[15:0], link_data_s_in};
            if (r_q.cnt == FRAME_LAST) begin
                r_d.cnt = '0;
                r_d.done = 1'b1;
            end else begin
                r_d.cnt = r_q.cnt + 5'h01;
            end
        end else if (fall && r_q.cnt != '0) begin
            r_d.tx = {r_q.tx[15:0], 1'b0};
        end else if (r_q.cnt == '0) begin
            r_d.tx = tx_word_in; // status bit leads the frame
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            r_q <= '{prev: 1'b0, cnt: '0, rx: '0, tx: TX_RST, done: 1'b0};
        end else begin
            r_q <= r_d;
        end
    end

    assign rx_word_out = r_q.rx;
    assign frame_done_out = r_q.done;
    assign link_data_out = r_q.tx[16];
endmodule
`default_nettype wire

// ==== hdl/dscd_top.sv ====
/*
  debug serial command decoder: takes 16-bit command words off the serial
  link, gathers extension words, runs the access and answers with status.
  assumes a bus port that acknowledges memory and register requests on
  clk_in, and a link clock far slower than clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
module dscd_top (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic link_clk_in,
    input wire logic link_data_in,
    output logic link_data_out,
    input wire logic cpu_halted_in,
    output logic resume_out,
    output dscd_pkg::dscd_mem_s mem_out,
    input wire logic mem_ack_in,
    input wire logic mem_err_in,
    input wire logic [31:0] mem_rdata_in,
    output dscd_pkg::dscd_reg_s reg_out,
    input wire logic reg_ack_in,
    input wire logic reg_err_in,
    input wire logic [31:0] reg_rdata_in,
    input wire logic [31:0] pc_in,
    output logic [3:0] trace_status_out,
    output logic [31:0] trace_data_out
);
    import dscd_pkg::*;

    // -------------------------------------------------
    // state
    // -------------------------------------------------
    typedef struct packed {
        dscd_state_e st;
        dscd_kind_e kind;
        logic [1:0] size;
        logic [11:0] idx;
        logic [31:0] addr;
        logic [31:0] data;
        logic [1:0] nad;
        logic [1:0] ndat;
        logic [16:0] tx;
        logic [15:0] lo;
        dscd_mem_s mem;
        dscd_reg_s rg;
        logic resume;
        logic [3:0] tstat;
        logic [31:0] tdata;
    } dscd_core_s;

    dscd_core_s r_q;
    dscd_core_s r_d;
    logic [1:0] pins_s;
    logic [16:0] rx_word;
    logic frame_done;
    logic [15:0] w;
    dscd_kind_e k;
    logic launch;
    logic halted_cls;
    logic [31:0] rd;
    logic [31:0] step;

    // -------------------------------------------------
    // link front end
    // -------------------------------------------------

    // link clock and data pass two flops first
    dscd_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .async_in({link_clk_in, link_data_in}),
        .sync_out(pins_s)
    );

    // frame shifter; response leaves high bit first
    dscd_shift u_shift (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .link_clk_s_in(pins_s[1]),
        .link_data_s_in(pins_s[0]),
        .tx_word_in(r_q.tx),
        .rx_word_out(rx_word),
        .frame_done_out(frame_done),
        .link_data_out(link_data_out)
    );

    // -------------------------------------------------
    // opcode decode
    // -------------------------------------------------

    // maps a command word onto its kind
    function automatic dscd_kind_e decode_cmd(input logic [15:0] c);
        dscd_kind_e dk;
        logic sz_ok;
        dk = K_ILL;
        sz_ok = (c[7:6] != SZ_RSVD) && (c[5:0] == 6'h00);
        if (c == OP_NOP) begin
            dk = K_NOP;
        end else if (c == OP_SYNC) begin
            dk = K_SYNC;
        end else if (c == OP_GO) begin
            dk = K_GO;
        end else if (c == OP_RCTL) begin
            dk = K_RCTL;
        end else if (c == OP_WCTL) begin
            dk = K_WCTL;
        end else if (c[15:4] == OP_RREG) begin
            dk = K_RREG;
        end else if (c[15:4] == OP_WREG) begin
            dk = K_WREG;
        end else if (c[15:8] == OP_RMEM && sz_ok) begin
            dk = K_RMEM;
        end else if (c[15:8] == OP_WMEM && sz_ok) begin
            dk = K_WMEM;
        end else if (c[15:8] == OP_DUMP && sz_ok) begin
            dk = K_DUMP;
        end else if (c[15:8] == OP_FILL && sz_ok) begin
            dk = K_FILL;
        end else if (c[15:8] == OP_RDBG && c[7:5] == OP_DBG_MID) begin
            dk = K_RDBG;
        end else if (c[15:8] == OP_WDBG && c[7:5] == OP_DBG_MID) begin
            dk = K_WDBG;
        end
        return dk;
    endfunction

    // number of data words a size needs
    function automatic logic [1:0] data_words(input logic [1:0] sz);
        return (sz == SZ_LONG) ? 2'h2 : 2'h1;
    endfunction

    // forces word and longword addresses onto their boundary
    function automatic logic [31:0] align(input logic [31:0] a,
                                          input logic [1:0] sz);
        logic [31:0] r;
        r = a;
        if (sz == SZ_WORD) begin
            r[0] = 1'b0;
        end else if (sz == SZ_LONG) begin
            r[1:0] = 2'h0;
        end
        return r;
    endfunction

    // -------------------------------------------------
    // command sequencer
    // -------------------------------------------------

    // one pass per cycle: decode, gather operands, execute, answer
    always_comb begin
        r_d = r_q;
        r_d.resume = 1'b0;
        r_d.tstat = 4'h0;
        w = rx_word[15:0];
        k = decode_cmd(w);
        launch = 1'b0;
        rd = 32'h0000_0000;
        step = 32'h0000_0000;
        halted_cls = 1'b0;
        case (r_q.st)
            ST_CMD: begin
                if (frame_done) begin
                    r_d.kind = k;
                    r_d.size = SZ_LONG;
                    r_d.nad = 2'h0;
                    r_d.ndat = 2'h0;
                    r_d.idx = 12'h000;
                    case (k)
                        K_RREG: begin
                            r_d.idx = {8'h00, w[3:0]};
                        end
                        K_WREG: begin
                            r_d.idx = {8'h00, w[3:0]};
                            r_d.ndat = 2'h2;
                        end
                        K_RMEM: begin
                            r_d.size = w[7:6];
                            r_d.nad = 2'h2;
                        end
                        K_WMEM: begin
                            r_d.size = w[7:6];
                            r_d.nad = 2'h2;
                            r_d.ndat = data_words(w[7:6]);
                        end
                        K_DUMP: begin
                            r_d.size = w[7:6];
                        end
                        K_FILL: begin
                            r_d.size = w[7:6];
                            r_d.ndat = data_words(w[7:6]);
                        end
                        K_RCTL: begin
                            r_d.nad = 2'h2;
                        end
                        K_WCTL: begin
                            r_d.nad = 2'h2;
                            r_d.ndat = 2'h2;
                        end
                        K_RDBG: begin
                            r_d.idx = {7'h00, w[4:0]};
                        end
                        K_WDBG: begin
                            r_d.idx = {7'h00, w[4:0]};
                            r_d.ndat = 2'h2;
                        end
                        default: begin
                        end
                    endcase
                    if (r_d.nad != 2'h0 || r_d.ndat != 2'h0) begin
                        r_d.tx = RESP_NRDY;
                        r_d.st = ST_EXT;
                    end else begin
                        launch = 1'b1;
                    end
                end
            end
            ST_EXT: begin
                // operands arrive high word first
                if (frame_done) begin
                    if (r_q.nad != 2'h0) begin
                        r_d.addr = {r_q.addr[15:0], w};
                        r_d.nad = r_q.nad - 2'h1;
                    end else begin
                        r_d.data = {r_q.data[15:0], w};
                        r_d.ndat = r_q.ndat - 2'h1;
                    end
                    if (r_d.nad == 2'h0 && r_d.ndat == 2'h0) begin
                        launch = 1'b1;
                    end
                end
            end
            ST_EXEC: begin
                // frames during the access still answer not-ready
                if (r_q.mem.req && mem_ack_in) begin
                    r_d.mem.req = 1'b0;
                    rd = mem_rdata_in;
                    if (r_q.size == SZ_BYTE) begin
                        rd = {24'h00_0000, mem_rdata_in[7:0]};
                    end else if (r_q.size == SZ_WORD) begin
                        rd = {16'h0000, mem_rdata_in[15:0]};
                    end
                    r_d.st = ST_CMD;
                    if (mem_err_in) begin
                        r_d.tx = RESP_BERR;
                    end else if (r_q.mem.wr) begin
                        r_d.tx = RESP_DONE;
                    end else if (r_q.size == SZ_LONG) begin
                        r_d.tx = {1'b0, rd[31:16]};
                        r_d.lo = rd[15:0];
                        r_d.st = ST_RES;
                    end else begin
                        r_d.tx = {1'b0, rd[15:0]};
                    end
                end else if (r_q.rg.req && reg_ack_in) begin
                    r_d.rg.req = 1'b0;
                    r_d.st = ST_CMD;
                    if (reg_err_in) begin
                        r_d.tx = RESP_BERR;
                    end else if (r_q.rg.wr) begin
                        r_d.tx = RESP_DONE;
                    end else begin
                        r_d.tx = {1'b0, reg_rdata_in[31:16]};
                        r_d.lo = reg_rdata_in[15:0];
                        r_d.st = ST_RES;
                    end
                end
            end
            ST_RES: begin
                // low word goes out while the next opcode comes in
                if (frame_done) begin
                    r_d.tx = {1'b0, r_q.lo};
                    r_d.st = ST_CMD;
                end
            end
            default: begin
                r_d.st = ST_CMD;
            end
        endcase

        // start the command once all operands are held
        if (launch) begin
            r_d.st = ST_CMD;
            halted_cls = (r_d.kind == K_RREG) || (r_d.kind == K_WREG) ||
                         (r_d.kind == K_GO) || (r_d.kind == K_RCTL) ||
                         (r_d.kind == K_WCTL);
            if (halted_cls && !cpu_halted_in) begin
                r_d.tx = RESP_BERR;
            end else begin
                case (r_d.kind)
                    K_NOP: begin
                        r_d.tx = RESP_DONE;
                    end
                    K_SYNC: begin
                        r_d.tstat = TRACE_PC_CODE;
                        r_d.tdata = pc_in;
                        r_d.tx = RESP_DONE;
                    end
                    K_GO: begin
                        r_d.resume = 1'b1;
                        r_d.tx = RESP_DONE;
                    end
                    K_RMEM, K_WMEM, K_DUMP, K_FILL: begin
                        // bus is shared with the processor, no halt
                        r_d.mem.req = 1'b1;
                        r_d.mem.wr = (r_d.kind == K_WMEM) ||
                                     (r_d.kind == K_FILL);
                        r_d.mem.size = r_d.size;
                        if (r_d.kind == K_DUMP || r_d.kind == K_FILL) begin
                            step = 32'h0000_0001 << r_d.size; // size of this command
                            r_d.addr = r_q.addr + step;
                        end
                        r_d.addr = align(r_d.addr, r_d.size);
                        r_d.mem.addr = r_d.addr;
                        r_d.mem.wdata = r_d.data;
                        r_d.tx = RESP_NRDY;
                        r_d.st = ST_EXEC;
                    end
                    K_RREG, K_WREG, K_RCTL, K_WCTL, K_RDBG, K_WDBG: begin
                        r_d.rg.req = 1'b1;
                        r_d.rg.wr = (r_d.kind == K_WREG) ||
                                    (r_d.kind == K_WCTL) ||
                                    (r_d.kind == K_WDBG);
                        r_d.rg.space = SP_GPR;
                        r_d.rg.idx = r_d.idx;
                        if (r_d.kind == K_RCTL || r_d.kind == K_WCTL) begin
                            r_d.rg.space = SP_CTL;
                            r_d.rg.idx = r_d.addr[11:0];
                        end else if (r_d.kind == K_RDBG ||
                                     r_d.kind == K_WDBG) begin
                            r_d.rg.space = SP_DBG;
                        end
                        r_d.rg.wdata = r_d.data;
                        r_d.tx = RESP_NRDY;
                        r_d.st = ST_EXEC;
                    end
                    default: begin
                        r_d.tx = RESP_ILL;
                    end
                endcase
            end
        end
    end

    // -------------------------------------------------
    // state register
    // -------------------------------------------------
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            r_q <= '0;
            r_q.st <= ST_CMD;
            r_q.kind <= K_NOP;
            r_q.tx <= TX_RST;
        end else begin
            r_q <= r_d;
        end
    end

    // -------------------------------------------------
    // outputs
    // -------------------------------------------------
    assign resume_out = r_q.resume;
    assign mem_out = r_q.mem;
    assign reg_out = r_q.rg;
    assign trace_status_out = r_q.tstat;
    assign trace_data_out = r_q.tdata;
endmodule
`default_nettype wire

// ==== verification/dscd_checker.sv ====
/* port assertions for the debug serial command decoder.
   assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/1ps
`default_nettype none
module dscd_checker
    import dscd_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic cpu_halted_in,
    input wire logic resume_out,
    input wire dscd_pkg::dscd_mem_s mem_out,
    input wire logic mem_ack_in,
    input wire dscd_pkg::dscd_reg_s reg_out,
    input wire logic reg_ack_in,
    input wire logic [31:0] pc_in,
    input wire logic [3:0] trace_status_out,
    input wire logic [31:0] trace_data_out
);
    // ------------------------------------------------
    // access and trace relations
    // ------------------------------------------------
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    a_mem_req_hold: assert property (mem_out.req && !mem_ack_in |=> mem_out.req && $stable(mem_out.addr))
        else $error("memory request dropped or moved before ack");
    a_mem_req_drop: assert property (mem_out.req && mem_ack_in |=> !mem_out.req)
        else $error("memory request still up after ack");
    a_mem_size_align: assert property (mem_out.req |-> mem_out.size != SZ_RSVD &&
        (mem_out.size == SZ_BYTE || !mem_out.addr[0]) && (mem_out.size != SZ_LONG || mem_out.addr[1:0] == 2'h0))
        else $error("memory request with bad size or alignment");
    a_one_access: assert property (!(mem_out.req && reg_out.req))
        else $error("memory and register requests together");
    a_halted_class: assert property ($rose(reg_out.req) && reg_out.space != SP_DBG |-> cpu_halted_in)
        else $error("halted class access while running");
    a_reg_req_hold: assert property (reg_out.req && !reg_ack_in |=> reg_out.req && $stable(reg_out.wdata))
        else $error("register request dropped before ack");
    a_reg_req_drop: assert property (reg_out.req && reg_ack_in |=> !reg_out.req)
        else $error("register request still up after ack");
    a_resume_pulse: assert property (resume_out |-> cpu_halted_in ##1 !resume_out)
        else $error("resume while running or too long");
    a_trace_pc: assert property (trace_status_out != 4'h0 |-> trace_status_out == TRACE_PC_CODE &&
        trace_data_out == $past(pc_in) ##1 trace_status_out == 4'h0)
        else $error("trace output wrong");
endmodule
bind dscd_top dscd_checker checker_inst (.clk_in, .sys_rst_in, .cpu_halted_in, .resume_out, .mem_out,
    .mem_ack_in, .reg_out, .reg_ack_in, .pc_in, .trace_status_out, .trace_data_out);
`default_nettype wire

// ==== verification/dscd_host_model.sv ====
/* host side of the serial link: sends 17-bit frames and gathers replies.
   assumes the decoder settles each reply bit within half a link period. */
`timescale 1ns/1ps
`default_nettype none
module dscd_host_model (
    output logic link_clk_out,
    output logic link_data_out,
    input wire logic resp_in
);
    // ------------------------------------------------
    // frame transfer
    // ------------------------------------------------
    initial begin
        link_clk_out = 1'b0;
        link_data_out = 1'b0;
    end
    // one frame high bit first, clock stands low between frames
    task automatic xfer(input logic [15:0] w, output logic [16:0] r);
        for (int i = 16; i >= 0; i--) begin
            link_data_out = (i == 16) ? 1'b0 : w[i];
            #40 link_clk_out = 1'b1;
            r[i] = resp_in;
            #40 link_clk_out = 1'b0;
        end
        link_data_out = ~link_data_out; // released line must not look held
        #200;
    endtask
endmodule
`default_nettype wire

// ==== verification/dscd_top_test.sv ====
/* self-checking bench for the command decoder.
   assumes the host model on the link and a prompt bus responder here. */
`timescale 1ns/1ps
`default_nettype none
module dscd_top_test;
    import dscd_pkg::*;
    typedef struct packed {logic h; logic [15:0] c; logic [16:0] e;} dscd_row_s;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic link_clk_in, link_data_in, link_data_out, resume_out;
    logic cpu_halted_in = 1'b1;
    logic mem_ack_in = 1'b0, mem_err_in = 1'b0, reg_ack_in = 1'b0, reg_err_in = 1'b0, err_mode = 1'b0;
    logic [31:0] mem_rdata_in = 32'h0, reg_rdata_in = 32'h0, pc_in = 32'h00004a5c, r;
    logic [3:0] trace_status_out;
    logic [31:0] trace_data_out;
    dscd_mem_s mem_out;
    dscd_reg_s reg_out;
    int miscompares = 0, checks_done = 0;
    int resumes = 0, syncs = 0;
    dscd_row_s rows [7] = '{'{1'b1, 16'h0000, 17'h0ffff}, '{1'b1, 16'h0001, 17'h0ffff},
        '{1'b1, 16'h3000, 17'h1ffff}, '{1'b1, 16'h1cc0, 17'h1ffff}, '{1'b0, 16'h2183, 17'h10001},
        '{1'b0, 16'h0c00, 17'h10001}, '{1'b1, 16'h0c00, 17'h0ffff}};
    // ------------------------------------------------
    // clock, design, host and bus responder
    // ------------------------------------------------
    initial forever #2.5 clk_in = ~clk_in;
    dscd_top dscd_top_inst (.clk_in, .sys_rst_in, .link_clk_in, .link_data_in, .link_data_out, .cpu_halted_in,
        .resume_out, .mem_out, .mem_ack_in, .mem_err_in, .mem_rdata_in, .reg_out, .reg_ack_in, .reg_err_in,
        .reg_rdata_in, .pc_in, .trace_status_out, .trace_data_out);
    dscd_host_model dscd_host_model_inst (.link_clk_out(link_clk_in), .link_data_out(link_data_in),
        .resp_in(link_data_out));
    // counts one-cycle resume and trace pulses away from the launching edge
    always @(negedge clk_in) begin
        resumes += int'(resume_out);
        syncs += int'(trace_status_out == TRACE_PC_CODE);
    end
    // one-cycle ack per request; read data is scrambled while idle
    always @(posedge clk_in) begin
        mem_ack_in <= mem_out.req && !mem_ack_in;
        mem_err_in <= err_mode;
        mem_rdata_in <= (mem_out.req && !mem_ack_in) ? {~mem_out.addr[15:0], mem_out.addr[15:0]} : ~mem_rdata_in;
        reg_ack_in <= reg_out.req && !reg_ack_in;
        reg_rdata_in <= (reg_out.req && !reg_ack_in) ? 32'h84213579 : ~reg_rdata_in;
    end
    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    task automatic tx(input logic [15:0] w);
        logic [16:0] t;
        dscd_host_model_inst.xfer(w, t);
        r = {15'h0, t};
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // watchdog well past the expected run time
    initial begin
        #150us;
        miscompares++;
        give_verdict();
    end
    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_in);
        chk("reset", {24'h0, link_data_out, mem_out.req, reg_out.req, resume_out, trace_status_out}, 32'h80);
        repeat (5) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        for (int i = 0; i < 7; i++) begin
            @(posedge clk_in) cpu_halted_in <= rows[i].h;
            tx(rows[i].c);
            tx(16'h0000);
            chk("row", r, {15'h0, rows[i].e});
        end
        chk("trace pc", trace_data_out, 32'h00004a5c);
        chk("pulses", {resumes[15:0], syncs[15:0]}, 32'h00010001);
        $display("table done");
        tx(16'h1980);
        tx(16'h0000);
        tx(16'h1002);
        chk("read addr", mem_out.addr, 32'h00001000);
        tx(16'h0000);
        chk("read hi", r, 32'h0efff);
        tx(16'h1d80);
        chk("read lo", r, 32'h01000);
        tx(16'h0000);
        chk("dump hi", r, 32'h0effb);
        tx(16'h0000);
        chk("dump lo", r, 32'h01004);
        err_mode = 1'b1;
        tx(16'h1900);
        tx(16'h0000);
        tx(16'h2001);
        tx(16'h0000);
        chk("bus error", r, 32'h10001);
        err_mode = 1'b0;
        $display("memory read done");
        tx(16'h1880);
        tx(16'h0000);
        tx(16'h3003);
        tx(16'hcafe);
        tx(16'hf00d);
        chk("write data", mem_out.wdata, 32'hcafef00d);
        tx(16'h1c40);
        chk("write done", r, 32'h0ffff);
        tx(16'hbeef);
        tx(16'h0000);
        chk("fill", {mem_out.addr[15:0], mem_out.wdata[15:0]}, 32'h3002beef);
        $display("memory write done");
        tx(16'h208b);
        tx(16'h1234);
        tx(16'h5678);
        chk("reg wdata", reg_out.wdata, 32'h12345678);
        tx(16'h2183);
        chk("reg wr done", r, 32'h0ffff);
        tx(16'h0000);
        chk("reg hi", r, 32'h08421);
        tx(16'h2d85);
        chk("reg lo", r, 32'h03579);
        tx(16'h0000);
        chk("dbg read", {r[15:0], 14'h0, reg_out.space}, 32'h84210002);
        tx(16'h2980);
        tx(16'h0000);
        tx(16'h0801);
        tx(16'h0000);
        chk("ctl read", {r[15:0], 4'h0, reg_out.idx}, 32'h84210801);
        tx(16'h2c85);
        tx(16'h1111);
        tx(16'h2222);
        tx(16'h0000);
        chk("dbg write", r, 32'h0ffff);
        $display("register access done");
        give_verdict();
    end
endmodule
`default_nettype wire
